// [design/prcn_top.sv]
// Functional notes
// [R1] input route registers hold two 6-bit pin numbers at 13:8 and 5:0
// [R2] bits 15:14 and 7:6 of select registers read zero, ignore writes
// [R3] output route registers hold two 6-bit function codes, one per pin
// [R4] select fields are read/write and clear to zero at reset
// [R5] a change on a watched pin raises the change interrupt
// [R6] only pins with their enable bit set can raise it
// [R7] per-pin pull-up and pull-down enable bits switch the weak pulls
// [R8] reading the port clears the mismatch and rearms detection
// [R9] detection keeps running in sleep and idle, setting the flag
// [R10] enabled flag in sleep or idle wakes the device
// [R11] priority not above cpu priority resumes after the sleep
// [R12] priority above cpu priority branches to the change vector
// [R13] software sets enables, pulls, clears flag, priority, then enable
// [R14] select write lock comes out of reset unlocked
// [R15] function code zero is the null function, pin not driven
// [R16] enabled pin levels compared to copy taken at last port read
`timescale 1ns/1ps
module prcn_top
   import prcn_pkg::*;
   (
   // clock, reset, enable
   input  wire logic                  clk_sys_in,
   input  wire logic                  rstn_in,
   input  wire logic                  ce_in,
   // register bus
   input  wire prcn_pkg::prcn_avs_req_t avs_req_in,
   output prcn_pkg::prcn_avs_rsp_t    avs_rsp_out,
   // remappable pins and peripherals
   input  wire logic [N_RP-1:0]       rp_pin_in,
   output logic      [N_RP-1:0]       rp_pin_out,
   output logic      [N_RP-1:0]       rp_pin_oe_out,
   input  wire logic [N_FUNC-1:0]     periph_func_in,
   output logic [2*N_IN_REG-1:0]      periph_sel_out,
   // change notify pins and pulls
   input  wire logic [N_CN-1:0]       cn_pin_in,
   output logic      [N_CN-1:0]       pull_up_out,
   output logic      [N_CN-1:0]       pull_down_out,
   // processor side
   input  wire logic                  low_power_in,
   input  wire logic [PRIO_W-1:0]     cpu_prio_in,
   output logic                       irq_out,
   output prcn_pkg::prcn_wake_t       wake_out
   );
   import prcn_pkg::*;

   typedef struct packed {
      prcn_bus_t            bus;
      logic [31:0]          rdata;
      logic                 wait_n;
      logic [N_RP-1:0]      rp_s1;
      logic [N_RP-1:0]      rp_s2;
      logic [N_CN-1:0]      cn_s1;
      logic [N_CN-1:0]      cn_s2;
      logic [N_CN-1:0]      snap;
      logic [N_CN-1:0]      cn_en;
      logic [N_CN-1:0]      pu;
      logic [N_CN-1:0]      pd;
      logic                 flag;
      logic                 mask;
      logic [PRIO_W-1:0]    prio;
      logic                 lock;
      logic [N_RP-1:0]      rp_do;
      logic [N_RP-1:0]      rp_oe;
      logic [2*N_IN_REG-1:0] psel;
      logic                 irq;
      prcn_wake_t           wake;
   } prcn_st_t;

   prcn_st_t st_q;
   prcn_st_t st_d;

   logic [N_SEL-1:0][2*FLD_W-1:0] sel_all;
   logic [2*FLD_W-1:0]            sel_rdata;
   logic [2*FLD_W-1:0]            sel_wdata;
   logic [SEL_AW-1:0]             sel_idx;
   logic                          sel_we;
   logic                          sel_hit;
   logic [5:0]                    wix;
   logic [N_RP-1:0]               rp_do_w;
   logic [N_RP-1:0]               rp_oe_w;
   logic [2*N_IN_REG-1:0]         psel_w;
   logic                          mismatch;
   logic                          take;

   // ==========================================
   // bus decode
   assign wix  = avs_req_in.address[7:2];
   assign take = (st_q.bus == BUS_ACK);
   always_comb
   begin
      sel_hit = 1'b0;
      sel_idx = '0;
      if (wix[5:SEL_AW] == IX_INSEL[5:SEL_AW])
      begin
         sel_hit = (wix[SEL_AW-1:0] < SEL_AW'(N_IN_REG));
         sel_idx = wix[SEL_AW-1:0];
      end
      else if (wix[5:SEL_AW] == IX_OUTSEL[5:SEL_AW])
      begin
         sel_hit = (wix[SEL_AW-1:0] < SEL_AW'(N_OUT_REG));
         sel_idx = SEL_AW'(N_IN_REG) + wix[SEL_AW-1:0];
      end
   end

   // merge write lanes over the fetched word; gaps are dropped
   always_comb
   begin
      sel_wdata = sel_rdata;
      if (avs_req_in.byteenable[0])
      begin
         sel_wdata[FLD_W-1:0] = avs_req_in.writedata[FLD_W-1:0]; // R1 R3
      end
      if (avs_req_in.byteenable[1])
      begin
         sel_wdata[2*FLD_W-1:FLD_W] =
            avs_req_in.writedata[FLD_HI_POS+FLD_W-1:FLD_HI_POS]; // R1 R3
      end
   end
   // locked select registers ignore writes
   assign sel_we = take && avs_req_in.write && sel_hit && !st_q.lock;

   prcn_sel_mem #(.DEPTH(N_SEL), .AW(SEL_AW), .DW(2*FLD_W)) u_sel_mem
   (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .ce_in      (ce_in),
      .we_in      (sel_we),
      .waddr_in   (sel_idx),
      .wdata_in   (sel_wdata),
      .raddr_in   (sel_idx),
      .rdata_out  (sel_rdata),
      .all_out    (sel_all)
   );

   // ==========================================
   // routing: one slice per peripheral input and per pin
   genvar g;
   generate
      for (g = 0; g < 2*N_IN_REG; g++)
      begin : g_in
         logic [FLD_W-1:0] pin;
         assign pin = sel_all[g/2][(g%2)*FLD_W +: FLD_W];
         // pin numbers past the last pin read as low
         assign psel_w[g] = (pin < FLD_W'(N_RP)) ?
                            st_q.rp_s2[pin[SEL_AW-1:0]] : 1'b0; // R1
      end
      for (g = 0; g < N_RP; g++)
      begin : g_out
         logic [FLD_W-1:0] code;
         logic             ok;
         assign code = sel_all[N_IN_REG + g/2][(g%2)*FLD_W +: FLD_W];
         // null and unknown codes leave the pin undriven
         assign ok = (code != FUNC_NULL) &&
                     (code <= FLD_W'(N_FUNC)); // R15
         assign rp_oe_w[g] = ok; // R3
         assign rp_do_w[g] = ok ?
                             periph_func_in[SEL_AW'(code - 6'h01)] : 1'b0;
      end
   endgenerate

   // mismatch of watched pins against the last port read
   assign mismatch = |((st_q.cn_s2 ^ st_q.snap) & st_q.cn_en); // R16 R6

   // ==========================================
   // next state
   always_comb
   begin
      st_d = st_q;
      st_d.rp_s1 = rp_pin_in;
      st_d.rp_s2 = st_q.rp_s1;
      st_d.cn_s1 = cn_pin_in;
      st_d.cn_s2 = st_q.cn_s1;
      st_d.rp_do = rp_do_w;
      st_d.rp_oe = rp_oe_w;
      st_d.psel  = psel_w;
      // bus walk: fetch, present answer, take
      case (st_q.bus)
         BUS_IDLE:
         begin
            if (avs_req_in.read || avs_req_in.write)
            begin
               st_d.bus = BUS_FETCH;
            end
         end
         BUS_FETCH:
         begin
            st_d.bus    = BUS_ACK;
            st_d.wait_n = 1'b1;
            st_d.rdata  = '0;
            if (sel_hit)
            begin
               st_d.rdata[FLD_HI_POS +: FLD_W] =
                  sel_rdata[2*FLD_W-1:FLD_W]; // R2
               st_d.rdata[FLD_LO_POS +: FLD_W] = sel_rdata[FLD_W-1:0];
            end
            else
            begin
               case (wix)
                  IX_PORT: st_d.rdata[N_CN-1:0] = st_q.cn_s2;
                  IX_CNEN: st_d.rdata[N_CN-1:0] = st_q.cn_en;
                  IX_PU:   st_d.rdata[N_CN-1:0] = st_q.pu;
                  IX_PD:   st_d.rdata[N_CN-1:0] = st_q.pd;
                  IX_STAT: st_d.rdata[STAT_CHG_BIT] = st_q.flag;
                  IX_MASK: st_d.rdata[STAT_CHG_BIT] = st_q.mask;
                  IX_PRIO: st_d.rdata[PRIO_W-1:0] = st_q.prio;
                  IX_LOCK: st_d.rdata[LOCK_BIT] = st_q.lock;
                  default: st_d.rdata = '0;
               endcase
            end
         end
         BUS_ACK:
         begin
            st_d.bus    = BUS_IDLE;
            st_d.wait_n = 1'b0;
            if (avs_req_in.read && wix == IX_PORT)
            begin
               st_d.snap = st_q.rdata[N_CN-1:0]; // R8
            end
            if (avs_req_in.write && !sel_hit)
            begin
               case (wix)
                  IX_CNEN: st_d.cn_en = avs_req_in.writedata[N_CN-1:0];
                  IX_PU:   st_d.pu = avs_req_in.writedata[N_CN-1:0]; // R7
                  IX_PD:   st_d.pd = avs_req_in.writedata[N_CN-1:0]; // R7
                  IX_STAT:
                  begin
                     if (avs_req_in.writedata[STAT_CHG_BIT])
                     begin
                        st_d.flag = 1'b0;
                     end
                  end
                  IX_MASK: st_d.mask = avs_req_in.writedata[STAT_CHG_BIT];
                  IX_PRIO: st_d.prio = avs_req_in.writedata[PRIO_W-1:0];
                  IX_LOCK: st_d.lock = avs_req_in.writedata[LOCK_BIT];
                  default: st_d.lock = st_q.lock;
               endcase
            end
         end
         default: st_d.bus = BUS_IDLE;
      endcase
      // detection runs whatever the power mode; set beats clear
      if (mismatch)
      begin
         st_d.flag = 1'b1; // R5 R9
      end
      st_d.irq = st_d.flag && st_d.mask;
      // wake and resume point from priority compare
      st_d.wake.wake = low_power_in && st_d.irq; // R10
      st_d.wake.to_vector = low_power_in && st_d.irq &&
                            (st_d.prio > cpu_prio_in); // R11 R12
   end

   // lock, fields and flags all start clear
   always_ff @(posedge clk_sys_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_q <= '0; // R14 R4
      end
      else if (ce_in)
      begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // outputs straight from state
   assign avs_rsp_out.readdata    = st_q.rdata;
   assign avs_rsp_out.waitrequest = !st_q.wait_n;
   assign rp_pin_out     = st_q.rp_do;
   assign rp_pin_oe_out  = st_q.rp_oe;
   assign periph_sel_out = st_q.psel;
   assign pull_up_out    = st_q.pu;
   assign pull_down_out  = st_q.pd;
   assign irq_out        = st_q.irq;
   assign wake_out       = st_q.wake;

   // ==========================================
   // checks
   sequence s_port_read;
      take && avs_req_in.read && wix == IX_PORT && ce_in;
   endsequence
   // the answer only moves on when the enable let the ack edge count
   sequence s_answer;
      st_q.bus == BUS_FETCH && ce_in ##1
      !avs_rsp_out.waitrequest && ce_in;
   endsequence

   a_bus_answer: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_answer |=> avs_rsp_out.waitrequest)
      else $error("answer not one cycle");
   a_port_rearm: assert property (@(posedge clk_sys_in) // R8
      disable iff (!rstn_in)
      s_port_read |=> st_q.snap == $past(avs_rsp_out.readdata[N_CN-1:0]))
      else $error("port read did not rearm");
   a_change_flag: assert property (@(posedge clk_sys_in) // R5
      disable iff (!rstn_in)
      mismatch && ce_in |=> st_q.flag)
      else $error("change missed");
   a_no_enable: assert property (@(posedge clk_sys_in) // R6
      disable iff (!rstn_in)
      st_q.cn_en == '0 && !st_q.flag && ce_in |=> !st_q.flag)
      else $error("flag without enable");
   a_reserved_zero: assert property (@(posedge clk_sys_in) // R2
      disable iff (!rstn_in)
      take && sel_hit |->
      avs_rsp_out.readdata[15:14] == 2'b00 &&
      avs_rsp_out.readdata[7:6] == 2'b00)
      else $error("reserved bits not zero");
   a_null_func: assert property (@(posedge clk_sys_in) // R15
      disable iff (!rstn_in)
      sel_all[N_IN_REG][FLD_W-1:0] == FUNC_NULL && ce_in
      |=> !rp_pin_oe_out[0])
      else $error("null code drives pin");
   a_vector_wake: assert property (@(posedge clk_sys_in) // R12
      disable iff (!rstn_in)
      wake_out.to_vector |-> wake_out.wake &&
      $past(st_d.prio) > $past(cpu_prio_in))
      else $error("vector without higher priority");
   a_resume_next: assert property (@(posedge clk_sys_in) // R11
      disable iff (!rstn_in)
      low_power_in && st_d.irq && st_d.prio <= cpu_prio_in && ce_in
      |=> wake_out.wake && !wake_out.to_vector)
      else $error("wrong resume point");
   a_wake_flag: assert property (@(posedge clk_sys_in) // R10
      disable iff (!rstn_in)
      wake_out.wake |-> irq_out && st_q.flag && st_q.mask)
      else $error("wake without pending flag");
   a_lock_reset: assert property (@(posedge clk_sys_in) // R14
      $rose(rstn_in) |-> !st_q.lock)
      else $error("lock set after reset");
   a_in_route: assert property (@(posedge clk_sys_in) // R1
      disable iff (!rstn_in)
      sel_all[0][FLD_W-1:0] == 6'h00 && ce_in
      |=> periph_sel_out[0] == $past(st_q.rp_s2[0]))
      else $error("input route wrong");
endmodule

// [design/prcn_pkg.sv]
package prcn_pkg;
   // ==========================================
   // sizes
   localparam int N_IN_REG  = 4;   // input route select registers
   localparam int N_OUT_REG = 4;   // output route select registers
   localparam int N_RP      = 2 * N_OUT_REG; // remappable pins
   localparam int N_FUNC    = 8;   // peripheral output functions
   localparam int N_CN      = 16;  // change notify pins
   localparam int FLD_W     = 6;
   localparam int PRIO_W    = 3;
   localparam int N_SEL     = N_IN_REG + N_OUT_REG;
   localparam int SEL_AW    = 3;
   // ==========================================
   // select register field layout
   localparam int FLD_LO_POS = 0;
   localparam int FLD_HI_POS = 8;
   localparam logic [FLD_W-1:0] FUNC_NULL = 6'h00;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   // ==========================================
   // word index map (byte address = 4 * index)
   localparam logic [5:0] IX_PORT  = 6'h00;
   localparam logic [5:0] IX_CNEN  = 6'h01;
   localparam logic [5:0] IX_PU    = 6'h02;
   localparam logic [5:0] IX_PD    = 6'h03;
   localparam logic [5:0] IX_STAT  = 6'h04;
   localparam logic [5:0] IX_MASK  = 6'h05;
   localparam logic [5:0] IX_PRIO  = 6'h06;
   localparam logic [5:0] IX_LOCK  = 6'h07;
   localparam logic [5:0] IX_INSEL = 6'h10;
   localparam logic [5:0] IX_OUTSEL = 6'h20;
   // status / mask bit and control bits
   localparam int STAT_CHG_BIT = 0;
   localparam int LOCK_BIT     = 0;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
   // ==========================================
   // carriers
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } prcn_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } prcn_avs_rsp_t;

   typedef struct packed {
      logic wake;       // leave sleep or idle
      logic to_vector;  // branch to vector, else next instruction
   } prcn_wake_t;

   typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ACK} prcn_bus_t;
endpackage

// [design/prcn_sel_mem.sv]
`timescale 1ns/1ps
module prcn_sel_mem
  #(parameter int DEPTH = 8,
    parameter int AW    = 3,
    parameter int DW    = 12)
   (
   // clock, reset and enable
   input  wire logic                clk_sys_in,
   input  wire logic                rstn_in,
   input  wire logic                ce_in,
   // write and read port
   input  wire logic                we_in,
   input  wire logic [AW-1:0]       waddr_in,
   input  wire logic [DW-1:0]       wdata_in,
   input  wire logic [AW-1:0]       raddr_in,
   output logic      [DW-1:0]       rdata_out,
   // every entry, for the routing logic
   output logic [DEPTH-1:0][DW-1:0] all_out
   );
   import prcn_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0]            rdata;
   } prcn_mem_st_t;

   prcn_mem_st_t st_q;
   prcn_mem_st_t st_d;

   // ==========================================
   // next state: registered read, plain write
   always_comb
   begin
      st_d = st_q;
      st_d.rdata = st_q.mem[raddr_in];
      if (we_in)
      begin
         st_d.mem[waddr_in] = wdata_in;
      end
   end

   // all fields clear at reset
   always_ff @(posedge clk_sys_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_q <= '0; // R4
      end
      else if (ce_in)
      begin
         st_q <= st_d;
      end
   end

   assign rdata_out = st_q.rdata;
   assign all_out   = st_q.mem;
endmodule

// [sim/prcn_pin_model.sv]
`timescale 1ns/1ps
// ==========================================
// far side: board pins and remappable peripherals
module prcn_pin_model
   (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // commands from the bench
   input  wire logic [7:0]  ext_rp_in,
   input  wire logic [15:0] ext_cn_in,
   input  wire logic [7:0]  func_cmd_in,
   // what the block drives onto the pins
   input  wire logic [7:0]  rp_drv_in,
   input  wire logic [7:0]  rp_oe_in,
   // levels seen by the block
   output logic      [7:0]  rp_lvl_out,
   output logic      [15:0] cn_lvl_out,
   output logic      [7:0]  func_out
   );
   // a driven pin shows the block's value, else the board's
   assign rp_lvl_out = (rp_oe_in & rp_drv_in) | (~rp_oe_in & ext_rp_in);
   assign cn_lvl_out = ext_cn_in;
   // peripherals update on the shared clock
   always_ff @(posedge clk_sys_in or negedge rstn_in)
   begin
      if (!rstn_in)
         func_out <= 8'h00;
      else
         func_out <= func_cmd_in;
   end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import prcn_pkg::*;
   // ==========================================
   // signals
   logic                  clk_sys_in;
   logic                  rstn_in;
   logic                  ce;
   logic                  low_pw;
   logic [PRIO_W-1:0]     cpu_prio;
   prcn_avs_req_t         req;
   prcn_avs_rsp_t         rsp;
   logic [N_RP-1:0]       rp_in;
   logic [N_RP-1:0]       rp_out;
   logic [N_RP-1:0]       rp_oe;
   logic [N_RP-1:0]       ext_rp;
   logic [N_FUNC-1:0]     func;
   logic [N_FUNC-1:0]     func_cmd;
   logic [2*N_IN_REG-1:0] psel;
   logic [N_CN-1:0]       cn;
   logic [N_CN-1:0]       ext_cn;
   logic [N_CN-1:0]       pu;
   logic [N_CN-1:0]       pd;
   logic                  irq;
   prcn_wake_t            wk;
   logic [31:0]           q;
   int                    fail_count;
   int                    num_checks;
   int                    cyc;
   // ==========================================
   // clock, block and far side
   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   prcn_top uut (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce),
      .avs_req_in(req), .avs_rsp_out(rsp),
      .rp_pin_in(rp_in), .rp_pin_out(rp_out), .rp_pin_oe_out(rp_oe),
      .periph_func_in(func), .periph_sel_out(psel),
      .cn_pin_in(cn), .pull_up_out(pu), .pull_down_out(pd),
      .low_power_in(low_pw), .cpu_prio_in(cpu_prio),
      .irq_out(irq), .wake_out(wk));
   prcn_pin_model pins (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .ext_rp_in(ext_rp), .ext_cn_in(ext_cn), .func_cmd_in(func_cmd),
      .rp_drv_in(rp_out), .rp_oe_in(rp_oe),
      .rp_lvl_out(rp_in), .cn_lvl_out(cn), .func_out(func));
   // ==========================================
   // tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   // one bus cycle; data taken at the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [5:0] ix,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_sys_in);
      req.read       <= !w;
      req.write      <= w;
      req.address    <= {ix, 2'b00};
      req.writedata  <= d;
      req.byteenable <= be;
      @(posedge clk_sys_in);
      while (rsp.waitrequest !== 1'b0)
         @(posedge clk_sys_in);
      q = rsp.readdata;
      req.read  <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] ix, input logic [31:0] d,
                     input logic [3:0] be = 4'hF);
      bus(1'b1, ix, d, be);
   endtask
   task automatic rd(input logic [5:0] ix, input logic [31:0] e,
                     input string n);
      bus(1'b0, ix, 32'h0000_0000, 4'hF);
      chk(n, e, q);
   endtask
   // settle time after a pin move: two sync flops plus a register
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   // ==========================================
   // hang guard, well above the expected run length
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      rstn_in = 1'b0;
      ce = 1'b1;
      req = '0;
      low_pw = 1'b0;
      cpu_prio = 3'h3;
      ext_rp = 8'h00;
      ext_cn = 16'h0000;
      func_cmd = 8'h02;
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      rd(IX_INSEL, 32'h0000_0000, "insel reset");
      rd(IX_OUTSEL, 32'h0000_0000, "outsel reset");
      rd(IX_LOCK, 32'h0000_0000, "lock reset");
      chk("oe reset", 32'h0, {24'h0, rp_oe});
      // all ones: only the two 6-bit fields keep them
      wr(IX_INSEL, 32'hFFFF_FFFF);
      rd(IX_INSEL, 32'h0000_3F3F, "insel fields");
      wr(IX_OUTSEL + 6'h01, 32'hFFFF_FFFF);
      rd(IX_OUTSEL + 6'h01, 32'h0000_3F3F, "outsel fields");
      wr(6'h0F, 32'hFFFF_FFFF);
      rd(6'h0F, 32'h0000_0000, "unmapped");
      // locked writes are dropped, unlocked ones land
      wr(IX_LOCK, 32'h1);
      wr(IX_INSEL + 6'h01, 32'h0000_0505);
      rd(IX_INSEL + 6'h01, 32'h0000_0000, "locked write");
      wr(IX_LOCK, 32'h0);
      wr(IX_INSEL + 6'h01, 32'h0000_0505);
      rd(IX_INSEL + 6'h01, 32'h0000_0505, "unlocked write");
      // only the high field lane is enabled
      wr(IX_INSEL + 6'h01, 32'h0000_0A0A, 4'h2);
      rd(IX_INSEL + 6'h01, 32'h0000_0A05, "lane write");
      // input routing: low field pin 3, high field pin 4
      wr(IX_INSEL, 32'h0000_0403);
      ext_rp <= 8'h08;
      wt(4);
      chk("route in", 32'h1, {30'h0, psel[1:0]});
      @(posedge clk_sys_in);
      ext_rp <= 8'h10;
      wt(4);
      chk("route in", 32'h2, {30'h0, psel[1:0]});
      // output routing: pin 0 function 2, pin 1 out of range
      wr(IX_OUTSEL, 32'h0000_0902);
      wt(3);
      chk("pin oe", 32'h01, {24'h0, rp_oe});
      chk("pin drive", 32'h1, {31'h0, rp_out[0]});
      @(posedge clk_sys_in);
      func_cmd <= 8'h00;
      wt(3);
      chk("pin drive", 32'h0, {31'h0, rp_out[0]});
      wr(IX_OUTSEL, 32'h0000_0000);
      wt(3);
      chk("null oe", 32'h00, {24'h0, rp_oe});
      // weak pulls follow their enable words
      wr(IX_PU, 32'h0000_A5A5);
      wr(IX_PD, 32'h0000_5A5A);
      wt(1);
      chk("pull up", 32'hA5A5, {16'h0, pu});
      chk("pull down", 32'h5A5A, {16'h0, pd});
      wr(IX_PU, 32'h0);
      wt(1);
      chk("pull up", 32'h0000, {16'h0, pu});
      // setup order: enables, flag clear, priority, then mask
      wr(IX_CNEN, 32'h0000_0004);
      wr(IX_STAT, 32'h1);
      wr(IX_PRIO, 32'h3);
      ext_cn <= 16'h0020;
      wt(4);
      rd(IX_STAT, 32'h0, "disabled pin");
      ext_cn <= 16'h0024;
      wt(4);
      rd(IX_STAT, 32'h1, "flag");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(IX_MASK, 32'h1);
      wt(2);
      chk("irq", 32'h1, {31'h0, irq});
      rd(IX_PORT, 32'h0000_0024, "port");
      wr(IX_STAT, 32'h1);
      wt(2);
      chk("irq rearm", 32'h0, {31'h0, irq});
      // sleep: equal priority resumes, higher branches
      @(posedge clk_sys_in);
      low_pw <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         wr(IX_PRIO, (i == 0) ? 32'h3 : 32'h5);
         ext_cn <= ext_cn ^ 16'h0004;
         wt(4);
         chk("sleep irq", 32'h1, {31'h0, irq});
         chk("wake", 32'h1, {31'h0, wk.wake});
         chk("vector", i, {31'h0, wk.to_vector});
         rd(IX_PORT, {16'h0, ext_cn}, "port");
         wr(IX_STAT, 32'h1);
         wt(2);
         chk("wake clear", 32'h0, {31'h0, wk.wake});
      end
      // enable low freezes detection, then it resumes
      @(posedge clk_sys_in);
      ce     <= 1'b0;
      low_pw <= 1'b0;
      ext_cn <= ext_cn ^ 16'h0004;
      wt(4);
      chk("frozen irq", 32'h0, {31'h0, irq});
      @(posedge clk_sys_in);
      ce <= 1'b1;
      wt(4);
      chk("awake irq", 32'h1, {31'h0, irq});
      chk("no wake", 32'h0, {31'h0, wk.wake});
      tally_and_finish();
   end
endmodule
